// ---- logic/sfpi_buf2.sv ----
// sfpi_buf2: two-entry buffer with valid/ready on both sides.
// assumes both sides run on sys_clk.
`timescale 1ns/1ns
module sfpi_buf2 #(
   parameter int W = 8
) (
   input  wire logic         sys_clk,   // core clock
   input  wire logic         arst_n,    // async reset, active low
   input  wire logic [W-1:0] in_data,   // word in
   input  wire logic         in_valid,  // word in present
   output logic              in_ready,  // room for a word
   output logic      [W-1:0] out_data,  // oldest word
   output logic              out_valid, // a word is held
   input  wire logic         out_ready  // drain side takes it
);
   typedef struct packed {
      logic [1:0][W-1:0] mem;
      logic              wp;
      logic              rp;
      logic [1:0]        cnt;
   } sfpi_buf_t;
   sfpi_buf_t q, d;
   logic push, pop;

   assign in_ready  = (q.cnt != 2'h2);
   assign out_valid = (q.cnt != 2'h0);
   assign out_data  = q.mem[q.rp];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always_comb begin
      d = q;
      if (push) begin
         d.mem[q.wp] = in_data;
         d.wp        = ~q.wp;
      end
      if (pop) begin
         d.rp = ~q.rp;
      end
      d.cnt = q.cnt + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule // sfpi_buf2

// ---- logic/sfpi_pkg.sv ----
// sfpi_pkg: constants, timing counts and state codes for the serial flash pin front end.
// assumes a 250 MHz sys_clk; every pin is sampled by that clock.
package sfpi_pkg;
   ////////////////////////////////////////////////////////////////////////////////////////////
   localparam int          CLK_PERIOD_NS      = 4;
   localparam int          RESET_LOW_MIN_NS   = 1000;
   localparam int          RESET_RECOVERY_NS  = 28000;
   // least times round up to whole cycles
   localparam int          RESET_LOW_MIN_CYC  = (RESET_LOW_MIN_NS + CLK_PERIOD_NS - 1)
                                                / CLK_PERIOD_NS;
   localparam int          RESET_RECOVERY_CYC = (RESET_RECOVERY_NS + CLK_PERIOD_NS - 1)
                                                / CLK_PERIOD_NS;
   localparam int          RST_CNT_W          = 8;
   localparam int          BYTE_BITS          = 8;
   localparam logic [3:0]  BYTE_BITS_CNT      = 4'h8;
   localparam logic [7:0]  IDLE_FILL          = 8'hff;
   ////////////////////////////////////////////////////////////////////////////////////////////
   localparam logic [1:0]  LANE_SINGLE        = 2'h0;
   localparam logic [1:0]  LANE_DUAL          = 2'h1;
   localparam logic [1:0]  LANE_QUAD          = 2'h2;
   localparam logic [3:0]  OE_SINGLE          = 4'h2;
   localparam logic [3:0]  OE_DUAL            = 4'h3;
   localparam logic [3:0]  OE_QUAD            = 4'hf;
   localparam logic        QE_RESET           = 1'b0;
   localparam logic        PRS_RESET          = 1'b0;
   ////////////////////////////////////////////////////////////////////////////////////////////
   localparam int          SYNC_W             = 6;
   localparam int          SYNC_SCK           = 0;
   localparam int          SYNC_CS            = 1;
   localparam int          SYNC_L0            = 2;
   localparam int          SYNC_L1            = 3;
   localparam int          SYNC_L2            = 4;
   localparam int          SYNC_L3            = 5;
   typedef enum logic [3:0] {
      SFPI_WAIT_HIGH = 4'h1,
      SFPI_IDLE      = 4'h2,
      SFPI_ACTIVE    = 4'h4,
      SFPI_RECOVER   = 4'h8
   } sfpi_state_t;
endpackage

// ---- logic/sfpi_sync.sv ----
// sfpi_sync: two flip-flop synchroniser for a group of pin levels.
// assumes inputs are asynchronous levels; output is the second stage only.
`timescale 1ns/1ns
module sfpi_sync #(
   parameter int W = 1
) (
   input  wire logic         sys_clk, // core clock
   input  wire logic         arst_n,  // async reset, active low
   input  wire logic [W-1:0] d_in,    // raw pin levels
   input  wire logic [W-1:0] rst_val, // unused-free idle level kept constant
   output logic      [W-1:0] d_out    // synchronised levels
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sfpi_sync_t;
   sfpi_sync_t q, d;

   always_comb begin
      d    = q;
      d.s1 = d_in;
      d.s2 = q.s1;
   end

   // pins idle high; reset value is all ones
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         q <= '1;
      end else begin
         q <= d;
      end
   end

   assign d_out = q.s2 & (rst_val | ~rst_val);
endmodule // sfpi_sync

// ---- logic/sfpi_top.sv ----
// sfpi_top: pin front end of a serial flash; select, lanes, pause and reset pin.
// assumes pins are asynchronous and sck is at most 1/8 of sys_clk; the core
// behind it interprets bytes and says when to drive and how many lanes to use.
`timescale 1ns/1ns

// Overview of operation
// - host uses clock mode 0 or 3; both sample rising, shift falling.
// - single lane captures instruction, address, data on sck rising edge.
// - single lane read data changes on sck falling edge on lane1.
// - dual and quad lanes capture rising, drive falling, direction by core.
// - select high means deselected, every lane output enable low.
// - select low makes device selected, bytes in and out flow.
// - deselect ends only the frame; internal write cycles keep running.
// - after power-up no instruction until select goes high then low.
// - write-protect low with status protect blocks status writes.
// - write-protect with protect bits locks part or all of the array.
// - in quad mode lane2 is data, write protect is off.
// - quad enable and pause/reset select come up zero.
// - pause works only with quad enable 0 and select bit 0.
// - pause low while selected tri-states output, ignores clock and input.
// - no pause in quad mode; lane3 carries data.
// - reset pin works only with quad enable 0 and select bit 1.
// - reset low for 1 us aborts work and returns to initial state.
// - no new instruction until 28 us after reset pin returns high.
// - no reset pin function in quad mode.
module sfpi_top #(
   parameter int RECOVERY_CYC = sfpi_pkg::RESET_RECOVERY_CYC
) (
   input  wire logic       sys_clk,                // core clock, 250 MHz
   input  wire logic       arst_n,                 // async reset, active low
   input  wire logic       sck,                    // serial clock pin
   input  wire logic       cs_n,                   // select pin, active low
   input  wire logic       lane0_in,               // serial_in / lane0 level
   output logic            lane0_out,              // lane0 drive value
   output logic            lane0_oe,               // lane0 drive enable
   input  wire logic       lane1_in,               // lane1 level
   output logic            lane1_out,              // serial out / lane1 value
   output logic            lane1_oe,               // lane1 drive enable
   input  wire logic       lane2_in,               // write protect / lane2 level
   output logic            lane2_out,              // lane2 drive value
   output logic            lane2_oe,               // lane2 drive enable
   input  wire logic       lane3_in,               // pause / reset / lane3 level
   output logic            lane3_out,              // lane3 drive value
   output logic            lane3_oe,               // lane3 drive enable
   input  wire logic [1:0] lane_mode,              // sfpi_pkg lane width code
   input  wire logic       drive_out,              // core: lanes face outward
   input  wire logic [7:0] tx_data,                // byte to shift out
   input  wire logic       tx_valid,               // tx byte present
   output logic            tx_ready,               // tx byte taken
   output logic      [7:0] rx_data,                // received byte
   output logic            rx_valid,               // received byte present
   input  wire logic       rx_ready,               // core takes rx byte
   output logic            rx_overrun,             // byte lost, buffer full
   output logic            frame_end,              // select returned high
   output logic            selected,               // frame open
   output logic            paused,                 // pause in force
   output logic            core_abort,             // reset pin abort pulse
   output logic            cmd_ready,              // instructions accepted
   input  wire logic       cfg_we,                 // write the two config bits
   input  wire logic       cfg_quad_enable,        // new quad_enable
   input  wire logic       cfg_pause_reset_select, // new pause_reset_select
   output logic            quad_enable,            // quad enable bit
   output logic            pause_reset_select,     // 0 pause, 1 reset on lane3
   input  wire logic       status_protect,         // status protect bit
   input  wire logic       protect_complement,     // protect complement bit
   input  wire logic       sector_granularity,     // sector granularity bit
   input  wire logic       top_bottom_select,      // top/bottom bit
   input  wire logic       block_protect_2,        // block protect bit 2
   input  wire logic       block_protect_1,        // block protect bit 1
   input  wire logic       block_protect_0,        // block protect bit 0
   output logic            status_write_block,     // status writes refused
   output logic            region_hw_locked        // protect map frozen by pin
);
   import sfpi_pkg::*;

   localparam int RCW = $clog2(RECOVERY_CYC + 1);
   localparam logic [RST_CNT_W-1:0] RST_DONE = RST_CNT_W'(RESET_LOW_MIN_CYC);
   localparam logic [RST_CNT_W-1:0] RST_LAST = RST_CNT_W'(RESET_LOW_MIN_CYC - 1);
   localparam logic [RCW-1:0]       REC_LAST = RCW'(RECOVERY_CYC - 1);

   typedef struct packed {
      sfpi_state_t          st;
      logic                 sck_prev;
      logic [1:0]           warm;
      logic [7:0]           rxsh;
      logic [3:0]           rxcnt;
      logic [7:0]           rxbyte;
      logic                 byte_vld;
      logic [7:0]           txsh;
      logic [3:0]           txcnt;
      logic [3:0]           dout;
      logic [3:0]           oe;
      logic                 pause;
      logic [RST_CNT_W-1:0] rcnt;
      logic [RCW-1:0]       rec;
      logic                 abort;
      logic                 fend;
      logic                 overrun;
      logic                 qe;
      logic                 prs;
      logic                 sw_block;
      logic                 reg_lock;
   } sfpi_top_t;
   sfpi_top_t q, d;

   logic [SYNC_W-1:0] pins_s;
   logic              sck_s, cs_s, hold_s, wp_s;
   logic              rise, fall, reset_fn, pause_fn, buf_in_ready;
   logic [1:0]        mode;
   logic [3:0]        nb, cnt_n;
   logic [7:0]        b;

   ////////////////////////////////////////////////////////////////////////////////////////////
   sfpi_sync #(
      .W       (SYNC_W)
   ) u_sync (
      .sys_clk (sys_clk),
      .arst_n  (arst_n),
      .d_in    ({lane3_in, lane2_in, lane1_in, lane0_in, cs_n, sck}),
      .rst_val ({SYNC_W{1'b1}}),
      .d_out   (pins_s)
   );

   assign sck_s    = pins_s[SYNC_SCK];
   assign cs_s     = pins_s[SYNC_CS];
   assign wp_s     = pins_s[SYNC_L2];
   assign hold_s   = pins_s[SYNC_L3];
   assign rise     = sck_s & ~q.sck_prev;
   assign fall     = ~sck_s & q.sck_prev;
   assign reset_fn = ~q.qe & q.prs;
   assign pause_fn = ~q.qe & ~q.prs;
   assign mode     = (lane_mode == LANE_QUAD && !q.qe) ? LANE_DUAL : lane_mode;
   assign nb       = (mode == LANE_QUAD) ? 4'h4 : (mode == LANE_DUAL) ? 4'h2 : 4'h1;
   // byte taken at the first falling edge of each outbound byte
   assign tx_ready = (q.st == SFPI_ACTIVE) & ~cs_s & ~q.pause & fall & drive_out
                     & (q.txcnt == 4'h0) & tx_valid;

   ////////////////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      d          = q;
      d.sck_prev = sck_s;
      // sync stages reset high; trust cs only once real pin levels arrive
      d.warm     = {q.warm[0], 1'b1};
      d.byte_vld = 1'b0;
      d.abort    = 1'b0;
      d.fend     = 1'b0;
      d.overrun  = q.byte_vld & ~buf_in_ready;
      cnt_n      = 4'h0;
      b          = q.txsh;
      if (cfg_we) begin
         d.qe  = cfg_quad_enable;
         d.prs = cfg_pause_reset_select;
      end
      d.sw_block = status_protect & ~wp_s & ~q.qe;
      d.reg_lock = d.sw_block & (protect_complement | sector_granularity | top_bottom_select
                                 | block_protect_2 | block_protect_1 | block_protect_0);
      if (!reset_fn || hold_s) begin
         d.rcnt = '0;
      end else if (q.rcnt != RST_DONE) begin
         d.rcnt = q.rcnt + 1'b1;
         d.abort = (q.rcnt == RST_LAST);
      end
      // pause follows lane3 only with sck low
      if (!pause_fn || cs_s || q.st != SFPI_ACTIVE) begin
         d.pause = 1'b0;
      end else if (!sck_s) begin
         d.pause = ~hold_s;
      end
      case (q.st)
         SFPI_WAIT_HIGH: begin
            if (cs_s && q.warm[1]) begin
               d.st = SFPI_IDLE;
            end
         end
         SFPI_IDLE: begin
            if (!cs_s) begin
               d.st    = SFPI_ACTIVE;
               d.rxcnt = 4'h0;
               d.txcnt = 4'h0;
            end
         end
         SFPI_ACTIVE: begin
            if (cs_s) begin
               d.st   = SFPI_IDLE;
               d.fend = 1'b1;
            end else if (!q.pause) begin
               if (rise && !drive_out) begin
                  case (mode)
                     LANE_SINGLE: d.rxsh = {q.rxsh[6:0], pins_s[SYNC_L0]};
                     LANE_DUAL:   d.rxsh = {q.rxsh[5:0], pins_s[SYNC_L1], pins_s[SYNC_L0]};
                     default:     d.rxsh = {q.rxsh[3:0], pins_s[SYNC_L3:SYNC_L0]};
                  endcase
                  cnt_n = q.rxcnt + nb;
                  if (cnt_n == BYTE_BITS_CNT) begin
                     d.rxcnt    = 4'h0;
                     d.rxbyte   = d.rxsh;
                     d.byte_vld = 1'b1;
                  end else begin
                     d.rxcnt = cnt_n;
                  end
               end
               if (fall && drive_out) begin
                  if (q.txcnt == 4'h0) begin
                     b = tx_valid ? tx_data : IDLE_FILL;
                  end
                  case (mode)
                     LANE_SINGLE: begin
                        d.dout = {2'b00, b[7], 1'b0};
                        d.txsh = {b[6:0], 1'b0};
                     end
                     LANE_DUAL: begin
                        d.dout = {2'b00, b[7:6]};
                        d.txsh = {b[5:0], 2'b00};
                     end
                     default: begin
                        d.dout = b[7:4];
                        d.txsh = {b[3:0], 4'h0};
                     end
                  endcase
                  cnt_n   = q.txcnt + nb;
                  d.txcnt = (cnt_n == BYTE_BITS_CNT) ? 4'h0 : cnt_n;
               end
            end
         end
         SFPI_RECOVER: begin
            if (!hold_s) begin
               d.rec = '0;
            end else if (q.rec == REC_LAST) begin
               d.rec = '0;
               d.st  = SFPI_WAIT_HIGH;
            end else begin
               d.rec = q.rec + 1'b1;
            end
         end
         default: d.st = SFPI_WAIT_HIGH;
      endcase
      if (d.abort) begin
         d.st    = SFPI_RECOVER;
         d.rec   = '0;
         d.rxcnt = 4'h0;
         d.txcnt = 4'h0;
         d.pause = 1'b0;
      end
      d.oe = 4'h0;
      if (d.st == SFPI_ACTIVE && !d.pause && drive_out) begin
         d.oe = (mode == LANE_QUAD) ? OE_QUAD : (mode == LANE_DUAL) ? OE_DUAL : OE_SINGLE;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         q          <= '0;
         q.st       <= SFPI_WAIT_HIGH;
         q.sck_prev <= 1'b1;
         q.qe       <= QE_RESET;
         q.prs      <= PRS_RESET;
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   sfpi_buf2 #(
      .W         (BYTE_BITS)
   ) u_rxbuf (
      .sys_clk   (sys_clk),
      .arst_n    (arst_n),
      .in_data   (q.rxbyte),
      .in_valid  (q.byte_vld),
      .in_ready  (buf_in_ready),
      .out_data  (rx_data),
      .out_valid (rx_valid),
      .out_ready (rx_ready)
   );

   assign {lane3_out, lane2_out, lane1_out, lane0_out} = q.dout;
   assign {lane3_oe, lane2_oe, lane1_oe, lane0_oe}     = q.oe;
   assign rx_overrun         = q.overrun;
   assign frame_end          = q.fend;
   assign selected           = (q.st == SFPI_ACTIVE);
   assign paused             = q.pause;
   assign core_abort         = q.abort;
   assign cmd_ready          = (q.st == SFPI_IDLE) | (q.st == SFPI_ACTIVE);
   assign quad_enable        = q.qe;
   assign pause_reset_select = q.prs;
   assign status_write_block = q.sw_block;
   assign region_hw_locked   = q.reg_lock;

   ////////////////////////////////////////////////////////////////////////////////////////////
   property p_desel_hiz;
      @(posedge sys_clk) disable iff (!arst_n)
      (q.st != SFPI_ACTIVE) |-> (q.oe == 4'h0);
   endproperty
   a_desel_hiz: assert property (p_desel_hiz) else $error("lanes driven while deselected");

   property p_select;
      @(posedge sys_clk) disable iff (!arst_n)
      (q.st == SFPI_IDLE && !cs_s && !d.abort) |=> (q.st == SFPI_ACTIVE);
   endproperty
   a_select: assert property (p_select) else $error("select low did not open frame");

   property p_powerup;
      @(posedge sys_clk) disable iff (!arst_n)
      (q.st == SFPI_WAIT_HIGH) |=> (q.st != SFPI_ACTIVE);
   endproperty
   a_powerup: assert property (p_powerup) else $error("frame opened without high select");

   property p_pause_hiz;
      @(posedge sys_clk) disable iff (!arst_n)
      q.pause |-> (q.oe == 4'h0 && !q.byte_vld);
   endproperty
   a_pause_hiz: assert property (p_pause_hiz) else $error("activity while paused");

   property p_quad_no_pause;
      @(posedge sys_clk) disable iff (!arst_n)
      q.qe |=> !q.pause;
   endproperty
   a_quad_no_pause: assert property (p_quad_no_pause) else $error("pause in quad mode");

   property p_abort_time;
      @(posedge sys_clk) disable iff (!arst_n)
      q.abort |-> (q.rcnt == RST_DONE && $past(q.rcnt) == RST_LAST && q.st == SFPI_RECOVER);
   endproperty
   a_abort_time: assert property (p_abort_time) else $error("abort timing wrong");

   property p_recovery;
      @(posedge sys_clk) disable iff (!arst_n)
      ($past(q.st) == SFPI_RECOVER && q.st == SFPI_WAIT_HIGH) |-> ($past(q.rec) == REC_LAST);
   endproperty
   a_recovery: assert property (p_recovery) else $error("recovery ended early");

   property p_quad_no_reset;
      @(posedge sys_clk) disable iff (!arst_n)
      q.qe |=> (q.rcnt == '0 && !q.abort);
   endproperty
   a_quad_no_reset: assert property (p_quad_no_reset) else $error("reset pin live in quad");

   property p_pause_sck_low;
      @(posedge sys_clk) disable iff (!arst_n)
      $rose(q.pause) |-> !$past(sck_s);
   endproperty
   a_pause_sck_low: assert property (p_pause_sck_low) else $error("pause entered, sck high");
endmodule // sfpi_top

// ---- sim/sfpi_host_model.sv ----
// sfpi_host_model: behavioural serial host driving clock, select and host-side lane levels.
// assumes sys_clk from the bench; one sck half lasts 8 sys_clk, a 64 ns period.
`timescale 1ns/1ns
module sfpi_host_model (
   input  wire logic       sys_clk, // core clock, paces the host
   input  wire logic       miso,    // lane1 level on the wire
   output logic            sck,     // serial clock, idle low
   output logic            cs_n,    // select, active low
   output logic      [3:0] mosi,    // host-driven lane levels
   output logic      [7:0] rd       // last eight bits read
);
   ////////////////////////////////////////////////////////////////////////////////////////////
   // select starts low so the bench can show the power-up refusal
   initial begin
      sck  = 1'b0;
      cs_n = 1'b0;
      mosi = 4'hf;
      rd   = 8'h00;
   end
   task automatic half();
      repeat (8) @(posedge sys_clk);
      #1;
   endtask
   // mode 0: data set while sck low, sampled after the rise
   task automatic clk_bit(input logic [3:0] v);
      mosi = v;
      half();
      rd   = {rd[6:0], miso};
      sck  = 1'b1;
      half();
      sck  = 1'b0;
   endtask
   task automatic send(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) clk_bit({3'b111, b[i]});
   endtask
   task automatic lvl(input logic [3:0] v);
      mosi = v;
      half();
   endtask
   task automatic sel(input logic v);
      cs_n = v;
      half();
   endtask
endmodule // sfpi_host_model

// ---- sim/sfpi_top_tb.sv ----
// sfpi_top_tb: self-checking bench for the serial flash pin front end.
// assumes sfpi_pkg and the design files are compiled first; recovery shortened to 20 cycles.
`timescale 1ns/1ns
module sfpi_top_tb;
   import sfpi_pkg::*;
   localparam int REC = 20;
   logic       sys_clk, arst_n, drive_out, tx_valid, rx_ready, cfg_we, cfg_qe, cfg_prs;
   logic       sp, fe, sck, cs_n, tx_ready, rx_valid, rx_overrun, selected, paused;
   logic       core_abort, cmd_ready, qe, prs, swb, rhl, ov_seen, ab_seen, fe_seen, tr_seen;
   logic [5:0] pb;
   logic [1:0] lane_mode;
   logic [7:0] tx_data, rx_data, rd;
   logic [3:0] l_out, l_oe, l_in, mosi;
   int         n_fail = 0;
   int         check_count = 0;
   assign l_in = (l_oe & l_out) | (~l_oe & mosi);
   sfpi_host_model sfpi_host_model_inst (.sys_clk(sys_clk), .miso(l_in[1]), .sck(sck),
      .cs_n(cs_n), .mosi(mosi), .rd(rd));
   sfpi_top #(.RECOVERY_CYC(REC)) sfpi_top_inst (.sys_clk(sys_clk), .arst_n(arst_n), .sck(sck),
      .cs_n(cs_n), .lane0_in(l_in[0]), .lane0_out(l_out[0]), .lane0_oe(l_oe[0]),
      .lane1_in(l_in[1]), .lane1_out(l_out[1]), .lane1_oe(l_oe[1]), .lane2_in(l_in[2]),
      .lane2_out(l_out[2]), .lane2_oe(l_oe[2]), .lane3_in(l_in[3]), .lane3_out(l_out[3]),
      .lane3_oe(l_oe[3]), .lane_mode(lane_mode), .drive_out(drive_out), .tx_data(tx_data),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
      .rx_ready(rx_ready), .rx_overrun(rx_overrun), .frame_end(fe), .selected(selected),
      .paused(paused), .core_abort(core_abort), .cmd_ready(cmd_ready), .cfg_we(cfg_we),
      .cfg_quad_enable(cfg_qe), .cfg_pause_reset_select(cfg_prs), .quad_enable(qe),
      .pause_reset_select(prs), .status_protect(sp), .protect_complement(pb[5]),
      .sector_granularity(pb[4]), .top_bottom_select(pb[3]), .block_protect_2(pb[2]),
      .block_protect_1(pb[1]), .block_protect_0(pb[0]), .status_write_block(swb),
      .region_hw_locked(rhl));
   ////////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      if (rx_overrun) ov_seen <= 1'b1;
      if (core_abort) ab_seen <= 1'b1;
      if (fe) fe_seen <= 1'b1;
      if (tx_ready) tr_seen <= 1'b1;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic check(input string nm, input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic cfg(input logic q, input logic p);
      cfg_qe  = q;
      cfg_prs = p;
      cfg_we  = 1'b1;
      cyc(1);
      cfg_we  = 1'b0;
      cyc(1);
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////////////////
   task automatic t_power();
      sfpi_host_model_inst.send(8'ha5);
      check("rx_valid", rx_valid, 8'h0);
      check("cmd_ready", cmd_ready, 8'h0);
      check("qe_prs", {qe, prs}, 8'h0);
      check("oe", l_oe, 8'h0);
      sfpi_host_model_inst.sel(1'b1);
      check("cmd_ready", cmd_ready, 8'h1);
      $display("test power done");
   endtask
   task automatic t_rx();
      ov_seen = 1'b0;
      sfpi_host_model_inst.sel(1'b0);
      check("selected", selected, 8'h1);
      sfpi_host_model_inst.send(8'ha5);
      sfpi_host_model_inst.send(8'h5a);
      sfpi_host_model_inst.send(8'h0f);
      check("overrun", ov_seen, 8'h1);
      check("rx_data", rx_data, 8'ha5);
      rx_ready = 1'b1;
      cyc(1);
      rx_ready = 1'b0;
      check("rx_data", rx_data, 8'h5a);
      rx_ready = 1'b1;
      cyc(1);
      rx_ready = 1'b0;
      check("rx_valid", rx_valid, 8'h0);
      sfpi_host_model_inst.sel(1'b1);
      check("selected", selected, 8'h0);
      check("frame_end", fe_seen, 8'h1);
      $display("test rx done");
   endtask
   task automatic t_read();
      drive_out = 1'b1;
      tx_data   = 8'h3c;
      tx_valid  = 1'b1;
      sfpi_host_model_inst.sel(1'b0);
      for (int i = 0; i < 9; i++) sfpi_host_model_inst.clk_bit(4'hf);
      check("read", rd, 8'h3c);
      check("tx_ready", tr_seen, 8'h1);
      check("oe", l_oe, {4'h0, OE_SINGLE});
      sfpi_host_model_inst.sel(1'b1);
      check("oe", l_oe, 8'h0);
      drive_out = 1'b0;
      tx_valid  = 1'b0;
      $display("test read done");
   endtask
   task automatic t_pause();
      logic [7:0] pat;
      pat = 8'ha5;
      sfpi_host_model_inst.sel(1'b0);
      for (int i = 7; i >= 4; i--) sfpi_host_model_inst.clk_bit({3'b111, pat[i]});
      sfpi_host_model_inst.lvl(4'h7);
      check("paused", paused, 8'h1);
      for (int i = 0; i < 4; i++) sfpi_host_model_inst.clk_bit(4'h7);
      sfpi_host_model_inst.lvl(4'hf);
      check("paused", paused, 8'h0);
      for (int i = 3; i >= 0; i--) sfpi_host_model_inst.clk_bit({3'b111, pat[i]});
      check("rx_valid", rx_valid, 8'h1);
      check("rx_data", rx_data, 8'ha5);
      rx_ready = 1'b1;
      sfpi_host_model_inst.sel(1'b1);
      rx_ready = 1'b0;
      $display("test pause done");
   endtask
   task automatic t_quad();
      cfg(1'b1, 1'b0);
      check("qe", qe, 8'h1);
      lane_mode = LANE_QUAD;
      sp        = 1'b1;
      sfpi_host_model_inst.sel(1'b0);
      sfpi_host_model_inst.clk_bit(4'h3);
      sfpi_host_model_inst.clk_bit(4'hc);
      check("rx_data", rx_data, 8'h3c);
      sfpi_host_model_inst.lvl(4'h0);
      check("paused", paused, 8'h0);
      check("swb", swb, 8'h0);
      rx_ready = 1'b1;
      sfpi_host_model_inst.sel(1'b1);
      rx_ready  = 1'b0;
      lane_mode = LANE_SINGLE;
      cfg(1'b0, 1'b0);
      pb = 6'h01;
      sfpi_host_model_inst.lvl(4'hb);
      check("swb", swb, 8'h1);
      check("rhl", rhl, 8'h1);
      pb = 6'h20;
      cyc(2);
      check("rhl", rhl, 8'h1);
      pb = 6'h00;
      cyc(2);
      check("rhl", rhl, 8'h0);
      sfpi_host_model_inst.lvl(4'hf);
      check("swb", swb, 8'h0);
      $display("test quad done");
   endtask
   task automatic t_reset();
      cfg(1'b0, 1'b1);
      ab_seen = 1'b0;
      sfpi_host_model_inst.lvl(4'h7);
      cyc(235);
      check("abort", ab_seen, 8'h0);
      cyc(20);
      check("abort", ab_seen, 8'h1);
      sfpi_host_model_inst.lvl(4'hf);
      check("cmd_ready", cmd_ready, 8'h0);
      cyc(REC + 10);
      check("cmd_ready", cmd_ready, 8'h1);
      cfg(1'b1, 1'b1);
      ab_seen = 1'b0;
      sfpi_host_model_inst.lvl(4'h7);
      cyc(300);
      check("abort", ab_seen, 8'h0);
      sfpi_host_model_inst.lvl(4'hf);
      $display("test reset done");
   endtask
   ////////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      {arst_n, drive_out, tx_valid, rx_ready, cfg_we, cfg_qe, cfg_prs, sp, pb} = 14'h0;
      {ov_seen, ab_seen, fe_seen, tr_seen} = 4'h0;
      lane_mode = LANE_SINGLE;
      tx_data   = 8'h00;
      repeat (20) @(posedge sys_clk);
      #1;
      arst_n = 1'b1;
      t_power();
      t_rx();
      t_read();
      t_pause();
      t_quad();
      t_reset();
      end_of_test();
   end
   initial begin
      #200000;
      n_fail++;
      end_of_test();
   end
endmodule // sfpi_top_tb
